//--- rtl/dsad_decoder.v
// Data space access decoder: address forming, region decode, lanes and config copy.
//
// Contract
// - Every 16-bit data address is a byte address; 64 Kbytes in total.
// - Addresses 0000h-7FFFh map to on-chip memory locations.
// - Addresses 8000h-FFFFh go to the extended data window.
// - General RAM of 8 Kbytes sits at 0800h-27FFh.
// - Low byte of a word at the even address, high byte at odd.
// - Post-increment adds one for byte operations, two for word operations.
// - Byte read fetches the word; bit 0 picks the byte onto the low lane.
// - Byte write strobes only the lane that matches the address.
// - Word access to an odd address raises the address error trap.
// - Misaligned read completes; misaligned write is suppressed; then trap.
// - Byte load into a working register leaves its high byte unchanged.
// - Sign-extend and zero-extend operations on a working register byte.
// - Near region 0000h-1FFFh is reachable through a 13-bit direct field.
// - Above near only indirect access, except 16-bit direct move addresses.
// - 0000h-07FFh decodes as the special function register region.
// - Unused register region addresses read as zero.
// - Register region splits into 32-byte regions, implemented or not.
// - Independent read and write address generators serve the data space.
// - At each reset the four top program words load the config registers.
`timescale 1ns/1ps
`default_nettype none
`include "dsad_map.vh"

module dsad_decoder (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Read address generator
	input wire rd_req,
	input wire [1:0] rd_mode,
	input wire [15:0] rd_ptr,
	input wire [15:0] rd_field,
	input wire rd_byte,
	input wire [1:0] rd_op,
	input wire [15:0] rd_wreg_old,
	output wire rd_ready,
	output wire [15:0] rd_ptr_next,
	output wire [15:0] rd_effective_byte_address,
	output reg rd_valid_q,
	output reg [15:0] rd_data_q,
	output reg [15:0] rd_wreg_new_q,
	// Write address generator
	input wire wr_req,
	input wire [1:0] wr_mode,
	input wire [15:0] wr_ptr,
	input wire [15:0] wr_field,
	input wire wr_byte,
	input wire [15:0] wr_data,
	output wire wr_ready,
	output wire [15:0] wr_ptr_next,
	output wire [15:0] wr_effective_byte_address,
	// Address error trap
	output reg trap_q,
	output reg trap_write_q,
	output reg [15:0] trap_addr_q,
	// Special function register region
	output wire sfr_rd_en,
	output wire [10:0] sfr_rd_addr,
	input wire [15:0] sfr_rd_data,
	output wire sfr_wr_en,
	output wire [10:0] sfr_wr_addr,
	output wire [1:0] sfr_wr_be,
	output wire [15:0] sfr_wr_lanes,
	// Extended data window
	output wire edw_rd_en,
	output wire [14:0] edw_rd_addr,
	input wire [15:0] edw_rd_data,
	output wire edw_wr_en,
	output wire [14:0] edw_wr_addr,
	output wire [1:0] edw_wr_be,
	output wire [15:0] edw_wr_lanes,
	// Program memory read for the config copy
	output wire pm_rd_req,
	output wire [23:0] pm_addr,
	input wire pm_rd_valid,
	input wire [23:0] pm_rd_data,
	// Config registers
	output wire cfg_done,
	output wire [23:0] cfg_word0,
	output wire [23:0] cfg_word1,
	output wire [23:0] cfg_word2,
	output wire [23:0] cfg_word3
);

	localparam [3:0] S_REQ = 4'h1;
	localparam [3:0] S_WAIT = 4'h2;
	localparam [3:0] S_DONE = 4'h4;
	localparam [3:0] S_IDLE = 4'h8;

	// Effective addresses of both generators, which work independently.
	reg [15:0] rd_ea;
	reg [15:0] wr_ea;

	always @* begin
		case (rd_mode)
			`DSAD_AM_INDIRECT: rd_ea = rd_ptr;
			`DSAD_AM_NEAR: rd_ea = {3'b000, rd_field[12:0]};
			`DSAD_AM_MOVE: rd_ea = rd_field;
			default: rd_ea = rd_ptr;
		endcase
	end

	always @* begin
		case (wr_mode)
			`DSAD_AM_INDIRECT: wr_ea = wr_ptr;
			`DSAD_AM_NEAR: wr_ea = {3'b000, wr_field[12:0]};
			`DSAD_AM_MOVE: wr_ea = wr_field;
			default: wr_ea = wr_ptr;
		endcase
	end

	assign rd_effective_byte_address = rd_ea;
	assign wr_effective_byte_address = wr_ea;

	// The pointer wraps within the 64 Kbyte space.
	assign rd_ptr_next = rd_ptr + (rd_byte ? `DSAD_STEP_BYTE : `DSAD_STEP_WORD);
	assign wr_ptr_next = wr_ptr + (wr_byte ? `DSAD_STEP_BYTE : `DSAD_STEP_WORD);

	// Config copy state.
	reg [3:0] cfg_st_q;
	reg [1:0] cfg_idx_q;
	reg [23:0] cfg_q [0:`DSAD_CFG_WORDS-1];

	assign cfg_done = cfg_st_q[3];
	// Data accesses wait until the configuration is in place.
	assign rd_ready = cfg_done;
	assign wr_ready = cfg_done;

	wire rd_go = rd_req & cfg_done;
	wire wr_go = wr_req & cfg_done;

	// Region decode, read side.
	wire rd_sfr = rd_ea <= `DSAD_SFR_END;
	wire rd_ram = (rd_ea >= `DSAD_RAM_BASE) & (rd_ea <= `DSAD_RAM_END);
	wire rd_edw = rd_ea >= `DSAD_EDW_BASE;
	wire [5:0] rd_rgn = rd_ea[10:`DSAD_SFR_REGION_LSB];
	wire [63:0] impl_map = `DSAD_SFR_IMPL_MAP;
	wire rd_sfr_impl = rd_sfr & impl_map[rd_rgn];
	wire rd_misal = ~rd_byte & rd_ea[0];

	// Region decode, write side.
	wire wr_sfr = wr_ea <= `DSAD_SFR_END;
	wire wr_ram = (wr_ea >= `DSAD_RAM_BASE) & (wr_ea <= `DSAD_RAM_END);
	wire wr_edw = wr_ea >= `DSAD_EDW_BASE;
	wire [5:0] wr_rgn = wr_ea[10:`DSAD_SFR_REGION_LSB];
	wire wr_sfr_impl = wr_sfr & impl_map[wr_rgn];
	wire wr_misal = ~wr_byte & wr_ea[0];

	// Lane strobes: a byte write touches its own lane only, an aligned word both, a misaligned word none.
	reg [1:0] wr_be;

	always @* begin
		if (wr_misal) begin
			wr_be = 2'b00;
		end else if (wr_byte) begin
			wr_be = wr_ea[0] ? 2'b10 : 2'b01;
		end else begin
			wr_be = 2'b11;
		end
	end

	wire [15:0] wr_lanes = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
	wire wr_any = wr_go & (wr_be != 2'b00);

	// Peripheral and window strobes; unimplemented regions are never strobed.
	assign sfr_rd_en = rd_go & rd_sfr_impl;
	assign sfr_rd_addr = {rd_ea[10:1], 1'b0};
	assign sfr_wr_en = wr_any & wr_sfr_impl;
	assign sfr_wr_addr = {wr_ea[10:1], 1'b0};
	assign sfr_wr_be = wr_be;
	assign sfr_wr_lanes = wr_lanes;

	assign edw_rd_en = rd_go & rd_edw;
	assign edw_rd_addr = {rd_ea[14:1], 1'b0};
	assign edw_wr_en = wr_any & wr_edw;
	assign edw_wr_addr = {wr_ea[14:1], 1'b0};
	assign edw_wr_be = wr_be;
	assign edw_wr_lanes = wr_lanes;

	// Data RAM as two byte-wide halves with shared word decode.
	wire [15:0] rd_ram_off = rd_ea - `DSAD_RAM_BASE;
	wire [15:0] wr_ram_off = wr_ea - `DSAD_RAM_BASE;
	wire [`DSAD_RAM_AW-1:0] rd_widx = rd_ram_off[`DSAD_RAM_AW:1];
	wire [`DSAD_RAM_AW-1:0] wr_widx = wr_ram_off[`DSAD_RAM_AW:1];
	wire [15:0] ram_rd_word;

	genvar ln;
	generate
		for (ln = 0; ln < 2; ln = ln + 1) begin : g_lane
			reg [7:0] mem [0:`DSAD_RAM_WORDS-1];
			reg [7:0] rd_q;

			// Read and write may hit the same word in one cycle; the read sees old data.
			always @(posedge clk_sys) begin
				if (wr_any & wr_ram & wr_be[ln]) begin
					mem[wr_widx] <= wr_lanes[8*ln+7:8*ln];
				end
				if (rd_go & rd_ram) begin
					rd_q <= mem[rd_widx];
				end
			end

			assign ram_rd_word[8*ln+7:8*ln] = rd_q;
		end
	endgenerate

	// Read stage one: remember what was asked.
	reg rd_v1_q;
	reg rd_ram_q;
	reg rd_sfr_q;
	reg rd_edw_q;
	reg rd_hi_q;
	reg rd_byte_q;
	reg [1:0] rd_op_q;
	reg [15:0] rd_old_q;

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			rd_v1_q <= 1'b0;
			rd_ram_q <= 1'b0;
			rd_sfr_q <= 1'b0;
			rd_edw_q <= 1'b0;
			rd_hi_q <= 1'b0;
			rd_byte_q <= 1'b0;
			rd_op_q <= `DSAD_OP_WORD;
			rd_old_q <= 16'h0000;
		end else begin
			rd_v1_q <= rd_go;
			if (rd_go) begin
				rd_ram_q <= rd_ram;
				rd_sfr_q <= rd_sfr_impl;
				rd_edw_q <= rd_edw;
				rd_hi_q <= rd_ea[0];
				rd_byte_q <= rd_byte;
				rd_op_q <= rd_op;
				rd_old_q <= rd_wreg_old;
			end
		end
	end

	// Whole word from the decoded source; the gap and empty regions give zero.
	reg [15:0] rd_word;

	always @* begin
		if (rd_ram_q) begin
			rd_word = ram_rd_word;
		end else if (rd_sfr_q) begin
			rd_word = sfr_rd_data;
		end else if (rd_edw_q) begin
			rd_word = edw_rd_data;
		end else begin
			rd_word = 16'h0000;
		end
	end

	// A misaligned word read still returns the aligned word: the instruction completes.
	wire [15:0] rd_steered = rd_byte_q ?
		{8'h00, (rd_hi_q ? rd_word[15:8] : rd_word[7:0])} : rd_word;
	wire [15:0] wreg_new;

	dsad_lane u_lane (
		.op(rd_op_q),
		.reg_old(rd_old_q),
		.data_in(rd_steered),
		.reg_new(wreg_new)
	);

	// Read stage two: registered answer.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= 16'h0000;
			rd_wreg_new_q <= 16'h0000;
		end else begin
			rd_valid_q <= rd_v1_q;
			if (rd_v1_q) begin
				rd_data_q <= rd_steered;
				rd_wreg_new_q <= wreg_new;
			end
		end
	end

	// Trap: the read completes first, so its trap waits for the read answer.
	reg rd_trap1_q;
	reg rd_trap2_q;
	reg [15:0] rd_tea1_q;
	reg [15:0] rd_tea2_q;

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			rd_trap1_q <= 1'b0;
			rd_trap2_q <= 1'b0;
			rd_tea1_q <= 16'h0000;
			rd_tea2_q <= 16'h0000;
		end else begin
			rd_trap1_q <= rd_go & rd_misal;
			rd_trap2_q <= rd_trap1_q;
			rd_tea1_q <= rd_ea;
			rd_tea2_q <= rd_tea1_q;
		end
	end

	// A write error is known at once; when both fire, the read error, whose instruction
	// came earlier, is reported and the write error's address and flag are not kept.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			trap_q <= 1'b0;
			trap_write_q <= 1'b0;
			trap_addr_q <= 16'h0000;
		end else begin
			trap_q <= rd_trap1_q | (wr_go & wr_misal);
			if (rd_trap1_q) begin
				trap_write_q <= 1'b0;
				trap_addr_q <= rd_tea1_q;
			end else if (wr_go & wr_misal) begin
				trap_write_q <= 1'b1;
				trap_addr_q <= wr_ea;
			end
		end
	end

	// Config copy after each reset.
	wire [23:0] cfg_off = {22'h000000, cfg_idx_q} * `DSAD_CFG_STEP;

	assign pm_rd_req = cfg_st_q[0];
	assign pm_addr = `DSAD_CFG_BASE + cfg_off;

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			cfg_st_q <= S_REQ;
			cfg_idx_q <= 2'h0;
		end else begin
			case (cfg_st_q)
				S_REQ: begin
					cfg_st_q <= S_WAIT;
				end
				S_WAIT: begin
					if (pm_rd_valid) begin
						if (cfg_idx_q == `DSAD_CFG_LAST) begin
							cfg_st_q <= S_DONE;
						end else begin
							cfg_idx_q <= cfg_idx_q + 2'h1;
							cfg_st_q <= S_REQ;
						end
					end
				end
				S_DONE: begin
					cfg_st_q <= S_IDLE;
				end
				S_IDLE: begin
					cfg_st_q <= S_IDLE;
				end
				default: begin
					cfg_st_q <= S_REQ;
				end
			endcase
		end
	end

	genvar cw;
	generate
		for (cw = 0; cw < `DSAD_CFG_WORDS; cw = cw + 1) begin : g_cfg
			always @(posedge clk_sys) begin
				if (!reset_n) begin
					cfg_q[cw] <= 24'h000000;
				end else if (cfg_st_q[1] & pm_rd_valid & (cfg_idx_q == cw)) begin
					cfg_q[cw] <= pm_rd_data;
				end
			end
		end
	endgenerate

	assign cfg_word0 = cfg_q[0];
	assign cfg_word1 = cfg_q[1];
	assign cfg_word2 = cfg_q[2];
	assign cfg_word3 = cfg_q[3];

endmodule // dsad_decoder
`default_nettype wire

//--- rtl/dsad_map.vh
// Address map, codes and timing constants of the data space access decoder.
`ifndef DSAD_MAP_VH
`define DSAD_MAP_VH

// Data space map (byte addresses).
`define DSAD_SFR_END 16'h07ff
`define DSAD_RAM_BASE 16'h0800
`define DSAD_RAM_END 16'h27ff
`define DSAD_NEAR_END 16'h1fff
`define DSAD_EDW_BASE 16'h8000
`define DSAD_RAM_WORDS 4096
`define DSAD_RAM_AW 12

// One bit per 32-byte decode region of the register region, bit i = addr[10:5].
`define DSAD_SFR_REGION_LSB 5
`define DSAD_SFR_IMPL_MAP 64'h00000ffe0fffffff

// Addressing modes of an address generator.
`define DSAD_AM_INDIRECT 2'h0
`define DSAD_AM_NEAR 2'h1
`define DSAD_AM_MOVE 2'h2

// Working register update operations.
`define DSAD_OP_WORD 2'h0
`define DSAD_OP_BYTE 2'h1
`define DSAD_OP_SIGN 2'h2
`define DSAD_OP_ZERO 2'h3

// Byte steps of the post-increment.
`define DSAD_STEP_BYTE 16'h0001
`define DSAD_STEP_WORD 16'h0002

// Configuration word copy from the top of program memory.
`define DSAD_CFG_BASE 24'h0157f8
`define DSAD_CFG_STEP 24'h000002
`define DSAD_CFG_WORDS 4
`define DSAD_CFG_LAST 2'h3

`endif

//--- rtl/dsad_lane.v
// Working register update for byte loads, word loads and byte extension.
`timescale 1ns/1ps
`default_nettype none
`include "dsad_map.vh"

module dsad_lane (
	// Operation
	input wire [1:0] op,
	// Old register value and lane-steered read data
	input wire [15:0] reg_old,
	input wire [15:0] data_in,
	// New register value
	output reg [15:0] reg_new
);

	always @* begin
		case (op)
			`DSAD_OP_WORD: reg_new = data_in;
			// The high byte is kept so that byte arithmetic leaves it intact.
			`DSAD_OP_BYTE: reg_new = {reg_old[15:8], data_in[7:0]};
			`DSAD_OP_SIGN: reg_new = {{8{data_in[7]}}, data_in[7:0]};
			`DSAD_OP_ZERO: reg_new = {8'h00, data_in[7:0]};
			default: reg_new = data_in;
		endcase
	end

endmodule // dsad_lane
`default_nettype wire

//--- bench/dsad_asserts.sv
// Assertion checker for the data space access decoder.
`timescale 1ns/1ps
`default_nettype none
`include "dsad_map.vh"

module dsad_asserts (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Read generator
	input wire rd_req,
	input wire [1:0] rd_mode,
	input wire [15:0] rd_ptr,
	input wire [15:0] rd_field,
	input wire rd_byte,
	input wire rd_ready,
	input wire [15:0] rd_ptr_next,
	input wire [15:0] rd_effective_byte_address,
	input wire rd_valid_q,
	input wire [15:0] rd_data_q,
	// Write generator and trap
	input wire wr_req,
	input wire wr_byte,
	input wire wr_ready,
	input wire [15:0] wr_effective_byte_address,
	input wire trap_q,
	input wire trap_write_q,
	input wire [15:0] trap_addr_q,
	// Targets
	input wire sfr_rd_en,
	input wire sfr_wr_en,
	input wire [1:0] sfr_wr_be,
	input wire edw_rd_en,
	input wire [14:0] edw_rd_addr,
	input wire edw_wr_en,
	input wire pm_rd_req,
	input wire [23:0] pm_addr
);
	localparam logic [63:0] IMPL = `DSAD_SFR_IMPL_MAP;
	wire [15:0] rd_eba = rd_effective_byte_address;
	wire [15:0] wr_eba = wr_effective_byte_address;

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	sequence rd_taken;
		rd_req && rd_ready;
	endsequence
	sequence rd_mis;
		rd_req && rd_ready && !rd_byte && rd_eba[0];
	endsequence
	sequence wr_mis;
		wr_req && wr_ready && !wr_byte && wr_eba[0];
	endsequence

	rd_answer_a: assert property (rd_taken |-> ##2 rd_valid_q)
		else $error("read answer missing");
	valid_cause_a: assert property (rd_valid_q |-> $past(rd_req && rd_ready, 2))
		else $error("read answer without request");
	ptr_step_a: assert property (rd_req |->
		rd_ptr_next == rd_ptr + (rd_byte ? `DSAD_STEP_BYTE : `DSAD_STEP_WORD))
		else $error("pointer step wrong");
	near_field_a: assert property (rd_req && rd_mode == `DSAD_AM_NEAR |->
		rd_eba == {3'h0, rd_field[12:0]})
		else $error("near address wrong");
	edw_route_a: assert property (rd_taken ##0 rd_eba[15] |->
		edw_rd_en && !sfr_rd_en && edw_rd_addr == {rd_eba[14:1], 1'b0})
		else $error("window routing wrong");
	unimpl_zero_a: assert property (rd_taken ##0 (rd_eba < 16'h0800 && !IMPL[rd_eba[10:5]])
		|-> !sfr_rd_en ##2 rd_data_q == 16'h0000)
		else $error("unused region read not zero");
	gap_zero_a: assert property (rd_taken ##0 (rd_eba inside {[16'h2800:16'h7fff]})
		|-> ##2 rd_data_q == 16'h0000)
		else $error("gap read not zero");
	byte_lane_a: assert property (wr_req && wr_ready && wr_byte && sfr_wr_en |->
		sfr_wr_be == (wr_eba[0] ? 2'h2 : 2'h1))
		else $error("byte lane wrong");
	wr_misalign_a: assert property (wr_mis |-> !sfr_wr_en && !edw_wr_en ##1 trap_q)
		else $error("misaligned write not trapped");
	rd_misalign_a: assert property (rd_mis |-> ##2 trap_q && !trap_write_q &&
		trap_addr_q == $past(rd_eba, 2))
		else $error("misaligned read not trapped");
	cfg_addr_a: assert property (pm_rd_req |-> pm_addr[23:3] == 21'h002aff && !pm_addr[0])
		else $error("config address wrong");
endmodule // dsad_asserts

bind dsad_decoder dsad_asserts i_chk (.*);
`default_nettype wire

//--- bench/dsad_mem_model.sv
// Register region, window and program memory responders.
`timescale 1ns/1ps
`default_nettype none

module dsad_mem_model (
	// Clock
	input wire clk_sys,
	// Register region and window
	input wire sfr_rd_en,
	input wire [10:0] sfr_rd_addr,
	output var logic [15:0] sfr_rd_data,
	input wire edw_rd_en,
	input wire [14:0] edw_rd_addr,
	output var logic [15:0] edw_rd_data,
	// Program memory
	input wire pm_rd_req,
	input wire [23:0] pm_addr,
	output var logic pm_rd_valid,
	output var logic [23:0] pm_rd_data
);
	initial begin
		{sfr_rd_data, edw_rd_data, pm_rd_valid, pm_rd_data} = '0;
	end

	// Unselected lines invert each cycle, so a stale sample never passes.
	always @(posedge clk_sys) begin
		sfr_rd_data <= sfr_rd_en ? {5'h15, sfr_rd_addr} : ~sfr_rd_data;
		edw_rd_data <= edw_rd_en ? {1'b1, edw_rd_addr} : ~edw_rd_data;
		pm_rd_valid <= pm_rd_req;
		pm_rd_data <= pm_rd_req ? pm_addr ^ 24'h5a5a5a : ~pm_rd_data;
	end
endmodule // dsad_mem_model
`default_nettype wire

//--- bench/dsad_decoder_tb.sv
// Self-checking testbench of the data space access decoder.
`timescale 1ns/1ps
`default_nettype none
`include "dsad_map.vh"

module dsad_decoder_tb;
	typedef struct packed {
		logic w;
		logic [1:0] m;
		logic [15:0] a;
		logic b;
		logic [1:0] op;
		logic [15:0] old, d, x;
	} dsad_row_t;
	logic clk_sys, reset_n, rd_req, rd_byte, wr_req, wr_byte;
	logic [1:0] rd_mode, rd_op, wr_mode;
	logic [15:0] rd_ptr, rd_field, rd_wreg_old, wr_ptr, wr_field, wr_data;
	wire rd_ready, rd_valid_q, wr_ready, trap_q, trap_write_q, sfr_rd_en, sfr_wr_en;
	wire edw_rd_en, edw_wr_en, pm_rd_req, pm_rd_valid, cfg_done;
	wire [15:0] rd_ptr_next, rd_effective_byte_address, rd_data_q, rd_wreg_new_q;
	wire [15:0] wr_ptr_next, wr_effective_byte_address, trap_addr_q, sfr_rd_data;
	wire [15:0] edw_rd_data, sfr_wr_lanes, edw_wr_lanes;
	wire [10:0] sfr_rd_addr, sfr_wr_addr;
	wire [14:0] edw_rd_addr, edw_wr_addr;
	wire [1:0] sfr_wr_be, edw_wr_be;
	wire [23:0] pm_addr, pm_rd_data, cfg_word0, cfg_word1, cfg_word2, cfg_word3;
	int num_errors = 0;
	int checked = 0;
	dsad_row_t rows [16];

	dsad_decoder i_dut (.*);
	dsad_mem_model i_mem (.*);

	initial begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [23:0] got, exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Requests are held one full cycle; ready is high once the copy is done.
	task automatic acc(input dsad_row_t r);
		@(negedge clk_sys);
		if (r.w)
			{wr_req, wr_mode, wr_ptr, wr_field, wr_byte, wr_data} = {1'b1, r.m, r.a, r.a, r.b, r.d};
		else
			{rd_req, rd_mode, rd_ptr, rd_field, rd_byte, rd_op, rd_wreg_old} =
				{1'b1, r.m, r.a, r.a, r.b, r.op, r.old};
		#1;
		chk(r.w ? wr_ptr_next : rd_ptr_next, r.a + (r.b ? 16'h1 : 16'h2));
		@(negedge clk_sys);
		rd_req = 0;
		wr_req = 0;
	endtask

	task automatic boot();
		logic [23:0] cw [4];
		@(negedge clk_sys);
		reset_n = 0;
		repeat (8) @(negedge clk_sys);
		chk({23'h0, cfg_done}, 24'h0);
		reset_n = 1;
		for (int i = 0; i < 200 && cfg_done !== 1'b1; i++)
			@(negedge clk_sys);
		chk({23'h0, cfg_done}, 24'h1);
		cw = '{cfg_word0, cfg_word1, cfg_word2, cfg_word3};
		for (int i = 0; i < 4; i++)
			chk(cw[i], (`DSAD_CFG_BASE + 24'(2 * i)) ^ 24'h5a5a5a);
	endtask

	task automatic wrap_up();
		$display("Checks %0d, errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge clk_sys);
		num_errors++;
		$display("Error at %0t: timeout", $time);
		wrap_up();
	end

	initial begin
		reset_n = 0;
		{rd_req, rd_byte, wr_req, wr_byte, rd_mode, rd_op, wr_mode} = '0;
		{rd_ptr, rd_field, rd_wreg_old, wr_ptr, wr_field, wr_data} = '0;
		rows = '{
			'{1, 2, 16'h0800, 0, 0, 0, 16'h1234, 0},
			'{1, 1, 16'he802, 0, 0, 0, 16'h5566, 0},
			'{1, 0, 16'h0803, 1, 0, 0, 16'h00ab, 0},
			'{1, 0, 16'h2800, 0, 0, 0, 16'hbeef, 0},
			'{1, 0, 16'h0021, 1, 0, 0, 16'h00cd, 0},
			'{0, 0, 16'h0800, 0, 0, 0, 16'h1234, 16'h1234},
			'{0, 0, 16'h0801, 1, 1, 16'hffff, 16'h0012, 16'hff12},
			'{0, 0, 16'h0803, 1, 2, 0, 16'h00ab, 16'hffab},
			'{0, 0, 16'h0803, 1, 3, 16'h1234, 16'h00ab, 16'h00ab},
			'{0, 0, 16'h0802, 0, 0, 0, 16'hab66, 16'hab66},
			'{0, 1, 16'he800, 0, 0, 0, 16'h1234, 16'h1234},
			'{0, 2, 16'h8004, 0, 0, 0, 16'h8004, 16'h8004},
			'{0, 0, 16'h0020, 0, 0, 0, 16'ha820, 16'ha820},
			'{0, 0, 16'h0380, 0, 0, 0, 0, 0},
			'{0, 0, 16'h2800, 0, 0, 0, 0, 0},
			'{0, 3, 16'h0802, 0, 0, 0, 16'hab66, 16'hab66}
		};
		boot();
		foreach (rows[i]) begin
			acc(rows[i]);
			if (!rows[i].w) begin
				// The answer pulse stands for one cycle only.
				@(negedge clk_sys);
				chk({23'h0, rd_valid_q}, 24'h1);
				chk(rd_data_q, rows[i].d);
				chk(rd_wreg_new_q, rows[i].x);
			end
		end
		acc('{1, 0, 16'h0804, 0, 0, 0, 16'h0f0f, 0});
		// The trap is a one-cycle pulse, so it is looked at while it stands.
		acc('{1, 0, 16'h0805, 0, 0, 0, 16'hdead, 0});
		chk({22'h0, trap_q, trap_write_q}, 24'h3);
		chk(trap_addr_q, 16'h0805);
		acc('{0, 0, 16'h0804, 0, 0, 0, 0, 0});
		repeat (2) @(negedge clk_sys);
		chk(rd_data_q, 16'h0f0f);
		acc('{0, 0, 16'h0801, 0, 0, 0, 0, 0});
		@(negedge clk_sys);
		chk({22'h0, trap_q, trap_write_q}, 24'h2);
		chk(trap_addr_q, 16'h0801);
		chk(rd_data_q, 16'h1234);
		@(negedge clk_sys);
		chk({23'h0, trap_q}, 24'h0);
		// Back-to-back writes with the request held: window byte, register word, empty region.
		@(negedge clk_sys);
		{wr_req, wr_mode, wr_ptr, wr_byte, wr_data} = {1'b1, 2'h0, 16'h8007, 1'b1, 16'h1242};
		#1;
		chk({edw_wr_en, sfr_wr_en, edw_wr_be, edw_wr_addr}, {1'b1, 1'b0, 2'h2, 15'h0006});
		chk(edw_wr_lanes, 16'h4242);
		@(negedge clk_sys);
		{wr_ptr, wr_byte, wr_data} = {16'h0022, 1'b0, 16'h7788};
		#1;
		chk({sfr_wr_en, edw_wr_en, sfr_wr_be, sfr_wr_addr}, {1'b1, 1'b0, 2'h3, 11'h022});
		chk(sfr_wr_lanes, 16'h7788);
		@(negedge clk_sys);
		wr_ptr = 16'h0380;
		#1;
		chk({22'h0, sfr_wr_en, edw_wr_en}, 24'h0);
		@(negedge clk_sys);
		wr_req = 0;
		chk({23'h0, trap_q}, 24'h0);
		boot();
		wrap_up();
	end
endmodule // dsad_decoder_tb
`default_nettype wire
